// >>> hdl/wdt_cfg.svh
// constants for the service timeout watchdog: reset values, terminal counts, delays
// assumes it is included by bare name from the package and the design modules
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// =====================================================================
// widths
`define WDT_CNT_WIDTH 16
`define WDT_PRE_WIDTH 14

// =====================================================================
// reset values: 254 slow ticks of 256 clocks, about 6.5 ms at 10 MHz
`define WDT_RELOAD_RESET 16'hff02
`define WDT_SEL_RESET 1'b0
`define WDT_SEL_DIV256 1'b0
`define WDT_SEL_DIV16384 1'b1

// =====================================================================
// counter limits
`define WDT_CNT_MAX 16'hffff
`define WDT_CNT_ONE 16'h0001
`define WDT_PRE_ZERO 14'h0000
`define WDT_PRE_ONE 14'h0001
`define WDT_PRE_LAST_256 14'h00ff
`define WDT_PRE_LAST_16384 14'h3fff

// =====================================================================
// warning delay: the reset request rises this many clocks plus one after the prewarning pulse
`define WDT_WARN_CYCLES 8'h10
`define WDT_WARN_ZERO 8'h00
`define WDT_WARN_ONE 8'h01

`endif

// >>> hdl/wdt_pkg.sv
// types shared by the watchdog modules
// assumes wdt_cfg.svh is reachable on the include path
`include "wdt_cfg.svh"

package wdt_pkg;
   // sequence after an overflow
   typedef enum logic [1:0] {
      st_run,
      st_warn,
      st_reset
   } wdt_state_type;

   // counter word
   typedef logic [`WDT_CNT_WIDTH-1:0] count_type;
endpackage

// >>> hdl/tick_if.sv
// carrier between the watchdog core and its prescaler
// assumes both ends share mclk
`timescale 1ns/1ns

interface tick_if;
   logic clear; // restart the prescaler from zero
   logic run; // prescaler advances while high
   logic sel_slow; // high selects division by 16384, low by 256
   logic tick; // one-cycle pulse at the end of a prescaler period

   modport core (output clear, output run, output sel_slow, input tick);
   modport divider (input clear, input run, input sel_slow, output tick);
endinterface

// >>> hdl/wdt_prescaler.sv
// prescaler that divides mclk into the watchdog tick enable
// assumes mclk and arst_n are those of the watchdog core
`timescale 1ns/1ns
`include "wdt_cfg.svh"

module wdt_prescaler #(
   parameter int WIDTH = `WDT_PRE_WIDTH
) (
   input wire logic mclk,
   input wire logic arst_n,
   tick_if.divider link
);
   import wdt_pkg::*;

   logic [WIDTH-1:0] pre_q; // prescaler count
   logic [WIDTH-1:0] last; // terminal count of the selected ratio

   // =====================================================================
   // ratio selection
   always_comb begin
      last = link.sel_slow ? WIDTH'(`WDT_PRE_LAST_16384) : WIDTH'(`WDT_PRE_LAST_256);
   end

   // tick in the last cycle of a period, never in a clearing cycle
   assign link.tick = link.run & ~link.clear & (pre_q == last);

   // =====================================================================
   // count, clear on service, hold while stopped
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= WIDTH'(`WDT_PRE_ZERO);
      end else if (link.clear) begin
         pre_q <= WIDTH'(`WDT_PRE_ZERO);
      end else if (link.run) begin
         // wrap at the terminal count
         if (pre_q == last) begin
            pre_q <= WIDTH'(`WDT_PRE_ZERO);
         end else begin
            pre_q <= pre_q + WIDTH'(`WDT_PRE_ONE);
         end
      end
      // stopped: hold
   end
endmodule // wdt_prescaler

// >>> hdl/service_timeout_watchdog.sv
// service timeout watchdog: 16-bit counter, prescaler, prewarning and reset request
// assumes the core gives one-cycle command strobes synchronous to mclk
`timescale 1ns/1ns
`include "wdt_cfg.svh"

module service_timeout_watchdog #(
   parameter int CNT_WIDTH = `WDT_CNT_WIDTH,
   parameter logic [7:0] WARN_CYCLES = `WDT_WARN_CYCLES
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic guard_service_command,
   input wire logic guard_enable_command,
   input wire logic guard_disable_command,
   input wire logic reload_write,
   input wire wdt_pkg::count_type guard_reload_value,
   input wire logic select_write,
   input wire logic select_slow,
   output logic prewarn_irq,
   output logic reset_request,
   output logic enabled_status,
   output wdt_pkg::count_type count_value
);
   import wdt_pkg::*;

   // =====================================================================
   // declarations
   tick_if link(); // carrier to the prescaler
   logic enabled_q; // watchdog running
   count_type reload_q; // programmed reload value
   logic sel_slow_q; // prescaler ratio selection
   count_type count_q; // watchdog counter
   wdt_state_type state_q; // overflow sequence
   logic [7:0] warn_q; // clocks left before the reset request
   logic prewarn_q; // prewarning pulse
   logic reset_req_q; // reset request level
   logic overflow; // counter wraps in this cycle
   logic enable_next; // enable state for the next cycle

   // =====================================================================
   // prescaler
   wdt_prescaler #(
      .WIDTH(`WDT_PRE_WIDTH)
   ) u_prescaler (
      .mclk(mclk),
      .arst_n(arst_n),
      .link(link)
   );

   // drive the prescaler controls
   always_comb begin
      link.clear = guard_service_command;
      link.run = enabled_q;
      link.sel_slow = sel_slow_q;
   end

   // =====================================================================
   // enable and disable commands, enable wins if both arrive together
   always_comb begin
      enable_next = enabled_q;
      if (guard_enable_command) begin
         enable_next = 1'b1;
      end else if (guard_disable_command) begin
         enable_next = 1'b0;
      end
   end

   // enable flag, set by reset so no software start is needed
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         enabled_q <= 1'b1;
      end else begin
         enabled_q <= enable_next;
      end
   end

   // =====================================================================
   // reload value and prescaler selection, written by the core
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reload_q <= `WDT_RELOAD_RESET;
      end else if (reload_write) begin
         reload_q <= guard_reload_value;
      end
   end

   // ratio selection with its reset default
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sel_slow_q <= `WDT_SEL_RESET;
      end else if (select_write) begin
         sel_slow_q <= select_slow;
      end
   end

   // =====================================================================
   // overflow: a tick while the counter stands at all ones
   always_comb begin
      overflow = enabled_q & link.tick & ~guard_service_command & (count_q == `WDT_CNT_MAX);
   end

   // counter: service has priority over the tick
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= `WDT_RELOAD_RESET;
      end else if (guard_service_command) begin
         count_q <= reload_q;
      end else if (enabled_q && link.tick) begin
         // wrap back to the reload value, otherwise count up
         if (count_q == `WDT_CNT_MAX) begin
            count_q <= reload_q;
         end else begin
            count_q <= count_q + `WDT_CNT_ONE;
         end
      end
      // disabled: hold
   end

   // =====================================================================
   // overflow sequence: prewarning pulse, delay, then held reset request
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= st_run;
         warn_q <= `WDT_WARN_ZERO;
      end else begin
         case (state_q)
            st_run: begin
               // first overflow starts the warning delay
               if (overflow) begin
                  state_q <= st_warn;
                  warn_q <= WARN_CYCLES;
               end
            end
            st_warn: begin
               // delay only runs while enabled
               if (enabled_q) begin
                  if (warn_q <= `WDT_WARN_ONE) begin
                     state_q <= st_reset;
                     warn_q <= `WDT_WARN_ZERO;
                  end else begin
                     warn_q <= warn_q - `WDT_WARN_ONE;
                  end
               end
            end
            st_reset: begin
               // held until the reset logic resets this block
               state_q <= st_reset;
            end
            default: begin
               state_q <= st_run;
               warn_q <= `WDT_WARN_ZERO;
            end
         endcase
      end
   end

   // prewarning pulse, one cycle after the overflowing tick
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prewarn_q <= 1'b0;
      end else begin
         prewarn_q <= overflow && (state_q == st_run);
      end
   end

   // reset request level, raised only while running so a disable in the
   // last warning cycle still keeps the request down
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reset_req_q <= 1'b0;
      end else if ((state_q == st_reset) && enabled_q) begin
         reset_req_q <= 1'b1;
      end
   end

   // =====================================================================
   // outputs, all from flip-flops
   assign prewarn_irq = prewarn_q;
   assign reset_request = reset_req_q;
   assign enabled_status = enabled_q;
   assign count_value = count_q;
endmodule // service_timeout_watchdog

// >>> verif/wdt_core_model.sv
// core-side model that issues the watchdog command strobes
// assumes the bench calls issue() hierarchically, one command at a time
`timescale 1ns/1ns

module wdt_core_model (
   input wire logic mclk,
   output logic svc,
   output logic en,
   output logic dis
);
   // strobes idle low from time zero
   initial begin
      svc = 1'b0;
      en = 1'b0;
      dis = 1'b0;
   end

   // one-cycle strobe; code bit 0 service, bit 1 enable, bit 2 disable
   task automatic issue(input logic [2:0] code);
      @(posedge mclk);
      #2;
      {dis, en, svc} = code;
      @(posedge mclk);
      #2;
      {dis, en, svc} = 3'b000;
   endtask
endmodule // wdt_core_model

// >>> verif/service_timeout_watchdog_asserts.sv
// port checker for the service timeout watchdog
// assumes it is bound to every service_timeout_watchdog instance
`timescale 1ns/1ns

module wdt_checker #(
   parameter logic [7:0] WARN_CYCLES = 8'h10
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic guard_service_command,
   input wire logic guard_enable_command,
   input wire logic guard_disable_command,
   input wire logic reload_write,
   input wire wdt_pkg::count_type guard_reload_value,
   input wire logic prewarn_irq,
   input wire logic reset_request,
   input wire logic enabled_status,
   input wire wdt_pkg::count_type count_value
);
   import wdt_pkg::*;
   count_type rel_q; // reload value as the design should hold it
   logic [8:0] warn_q; // enabled cycles since the prewarning pulse

   // shadow of the reload value
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) rel_q <= 16'hff02;
      else if (reload_write) rel_q <= guard_reload_value;
   end

   // counts the warning delay, only while enabled
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) warn_q <= 9'h000;
      else if (prewarn_irq) warn_q <= 9'h001;
      else if (warn_q != 9'h000 && enabled_status) warn_q <= warn_q + 9'h001;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_boot_state: assert property ($rose(arst_n) |-> enabled_status && count_value == 16'hff02)
      else $error("wrong state after reset");
   a_enable_cmd: assert property (guard_enable_command |=> enabled_status)
      else $error("enable not taken");
   a_disable_cmd: assert property (guard_disable_command && !guard_enable_command |=> !enabled_status)
      else $error("disable not taken");
   a_service_load: assert property (guard_service_command && !reload_write |=> count_value == rel_q)
      else $error("service did not reload");
   a_count_step: assert property (enabled_status && !guard_service_command && !guard_disable_command |=>
      count_value == $past(count_value) || count_value == $past(count_value) + 16'h0001 ||
      ($past(count_value) == 16'hffff && count_value == $past(rel_q)))
      else $error("counter moved wrongly");
   a_frozen_off: assert property (!enabled_status && !guard_enable_command && !guard_service_command |=>
      $stable(count_value) && !prewarn_irq)
      else $error("disabled watchdog moved");
   a_overflow_warn: assert property (prewarn_irq |-> $past(count_value) == 16'hffff)
      else $error("prewarning without overflow");
   a_warn_pulse: assert property (prewarn_irq |=> !prewarn_irq)
      else $error("prewarning too long");
   a_reset_held: assert property (reset_request |=> reset_request)
      else $error("reset request dropped");
   a_warn_delay: assert property ($rose(reset_request) |-> warn_q == {1'b0, WARN_CYCLES} + 9'h001)
      else $error("reset request at wrong time");

   c_service: cover property (guard_service_command);
   c_prewarn: cover property (prewarn_irq);
   c_reset: cover property ($rose(reset_request));
endmodule // wdt_checker

bind service_timeout_watchdog wdt_checker #(.WARN_CYCLES(WARN_CYCLES)) u_chk (.mclk, .arst_n,
   .guard_service_command, .guard_enable_command, .guard_disable_command, .reload_write,
   .guard_reload_value, .prewarn_irq, .reset_request, .enabled_status, .count_value);

// >>> verif/test_service_timeout_watchdog.sv
// self-checking bench for the service timeout watchdog
// assumes the core model and the checker are compiled before it
`timescale 1ns/1ns

module test_service_timeout_watchdog;
   import wdt_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("FAIL %0t got %h", $time, a); end end
   localparam int WARN = 4; // shortened warning delay
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic rw; // reload write strobe
   logic sw; // select write strobe
   logic ss; // select value, high for the slow ratio
   count_type rv; // reload value, random in the low byte for the first three writes, fixed after
   logic svc, en, dis, irq, rreq, ena;
   count_type cnt, held;
   int n_errors = 0;
   int samples_checked = 0;
   int k;
   logic [31:0] lfsr = 32'hef616ff0;

   always #25 mclk = ~mclk;

   wdt_core_model u_core (.mclk, .svc, .en, .dis);
   service_timeout_watchdog #(.WARN_CYCLES(8'(WARN))) u_dut (.mclk, .arst_n, .guard_service_command(svc),
      .guard_enable_command(en), .guard_disable_command(dis), .reload_write(rw), .guard_reload_value(rv),
      .select_write(sw), .select_slow(ss), .prewarn_irq(irq), .reset_request(rreq), .enabled_status(ena),
      .count_value(cnt));

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected counter after a number of ticks
   function automatic count_type after_ticks(input count_type r, input int t);
      return r + count_type'(t);
   endfunction

   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // bounded wait for prewarning (0) or reset request (1)
   task automatic wait_high(input bit which);
      for (k = 0; k < 3000 && (which ? rreq : irq) !== 1'b1; k++) cycles(1);
      if (k == 3000) begin
         n_errors++;
         print_verdict();
      end
   endtask

   task automatic write_cfg(input count_type r, input logic slow);
      rv = r;
      ss = slow;
      rw = 1'b1;
      sw = 1'b1;
      cycles(1);
      rw = 1'b0;
      sw = 1'b0;
   endtask

   initial begin
      // configuration strobes quiet until the first write
      rw = 1'b0;
      sw = 1'b0;
      ss = 1'b0;
      rv = 16'h0000;
      cycles(10);
      arst_n = 1'b1;
      `CHK(ena, 1'b1)
      `CHK(cnt, 16'hff02)
      cycles(250);
      `CHK(cnt, 16'hff02)
      cycles(10);
      `CHK(cnt, after_ticks(16'hff02, 1))
      repeat (3) begin
         lfsr = next_rand(lfsr);
         write_cfg({8'hf0, lfsr[7:0]}, 1'b0);
         cycles(200);
         u_core.issue(3'b001);
         `CHK(cnt, rv)
         cycles(250);
         `CHK(cnt, rv)
         cycles(10);
         `CHK(cnt, after_ticks(rv, 1))
      end
      write_cfg(16'h1234, 1'b1);
      u_core.issue(3'b001);
      cycles(16370);
      `CHK(cnt, 16'h1234)
      cycles(30);
      `CHK(cnt, 16'h1235)
      write_cfg(16'h1234, 1'b0);
      u_core.issue(3'b100);
      held = cnt;
      `CHK(ena, 1'b0)
      cycles(600);
      `CHK(cnt, held)
      u_core.issue(3'b110);
      `CHK(ena, 1'b1)
      write_cfg(16'hfffe, 1'b0);
      u_core.issue(3'b001);
      wait_high(1'b0);
      `CHK(k > 500 && k < 520, 1'b1)
      `CHK(cnt, 16'hfffe)
      `CHK(rreq, 1'b0)
      u_core.issue(3'b001);
      wait_high(1'b1);
      `CHK(k, WARN - 1)
      cycles(20);
      `CHK(rreq, 1'b1)
      // mid-run reset drops the held request and restores the defaults
      arst_n = 1'b0;
      cycles(2);
      `CHK(rreq, 1'b0)
      `CHK(cnt, 16'hff02)
      arst_n = 1'b1;
      cycles(1);
      `CHK(ena, 1'b1)
      print_verdict();
   end
endmodule // test_service_timeout_watchdog
